// file: inc/hbw_pkg.sv
package hbw_pkg;

  // ****************************************************
  // Register indices (byte address = index * 4)
  // ****************************************************
  localparam logic [9:0] IDX_EVT_TYPE = 10'h015;
  localparam logic [9:0] IDX_EVT_DATA = 10'h016;
  localparam logic [9:0] IDX_HALT_MASK = 10'h018;
  localparam logic [9:0] IDX_DBG_MODE = 10'h01A;
  localparam logic [9:0] IDX_MAILBOX = 10'h020;
  localparam logic [9:0] IDX_IB_TARGET = 10'h030;
  localparam logic [9:0] IDX_IB_CTRL = 10'h040;
  localparam logic [9:0] IDX_DW_FIRST = 10'h050;
  localparam logic [9:0] IDX_DW_SECOND = 10'h060;
  localparam logic [9:0] IDX_DW_CTRL = 10'h070;
  localparam logic [9:0] IDX_RW_MASK = 10'h080;
  localparam logic [9:0] IDX_RW_VALUE = 10'h090;
  localparam logic [9:0] IDX_RW_CTRL = 10'h09C;

  // ****************************************************
  // Field positions and writable bits
  // ****************************************************
  localparam int CTL_ENABLE = 0;
  localparam int CTL_SELECT = 1;
  localparam int CTL_LOAD = 2;
  localparam int CTL_THREADS = 16;
  localparam int DMC_HOST_REQ = 0;
  localparam int DMC_RETURN = 1;
  localparam int DMC_IN_DEBUG = 0;
  localparam logic [31:0] IB_CTRL_WMASK = 32'h00FF0003;
  localparam logic [31:0] DW_CTRL_WMASK = 32'h00FF0007;
  localparam logic [31:0] RW_CTRL_WMASK = 32'h00FF0003;

  // ****************************************************
  // Reset values and cause codes
  // ****************************************************
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [7:0] HALT_RESET = 8'h00;
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_DCALL = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;

  typedef struct packed {
    logic [31:0] evt_data;
    logic [7:0] halt_mask;
    logic [7:0][31:0] mailbox;
    logic [3:0][31:0] ib_target;
    logic [3:0][31:0] ib_ctrl;
    logic [3:0][31:0] dw_first;
    logic [3:0][31:0] dw_second;
    logic [3:0][31:0] dw_ctrl;
    logic [3:0][31:0] rw_mask;
    logic [3:0][31:0] rw_value;
    logic [3:0][31:0] rw_ctrl;
    logic [2:0] cause;
    logic [7:0] cause_thread;
    logic [1:0] cause_unit;
    logic in_debug;
    logic enter_pulse;
    logic [31:0] prdata;
  } hbw_state_t;

endpackage

// file: design/hbw_unit.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ns

module hbw_unit #(
  parameter int NUM_THREADS = 8,
  parameter int NUM_UNITS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] thr_pc_valid,
  input wire logic [7:0][31:0] thr_pc,
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire logic [2:0] mem_thread,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [2:0] res_thread,
  input wire logic [31:0] res_id,
  input wire logic dcall_valid,
  input wire logic [2:0] dcall_thread,
  input wire logic cfg_mbox_wr,
  input wire logic [2:0] cfg_mbox_idx,
  input wire logic [31:0] cfg_mbox_wdata,
  output logic [31:0] cfg_mbox_rdata,
  output logic [7:0] thread_halt,
  output logic in_debug_mode,
  output logic debug_enter
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [1:0] first_hit(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic thr_ok(input logic [31:0] ctl,
                                  input logic [2:0] thr);
    return ctl[hbw_pkg::CTL_ENABLE] && ctl[hbw_pkg::CTL_THREADS + thr];
  endfunction

  function automatic logic in_group(input logic [9:0] idx,
                                    input logic [9:0] base);
    return idx[9:2] == base[9:2];
  endfunction

  function automatic logic [32:0] reg_read(input hbw_pkg::hbw_state_t s,
                                           input logic [9:0] idx);
    logic [32:0] r;
    logic [1:0] k;
    r = 33'h000000000;
    k = idx[1:0];
    if (idx == hbw_pkg::IDX_EVT_TYPE) begin
      r = {1'b1, 14'h0000, s.cause_unit, s.cause_thread, 5'h00, s.cause};
    end else if (idx == hbw_pkg::IDX_EVT_DATA) begin
      r = {1'b1, s.evt_data};
    end else if (idx == hbw_pkg::IDX_HALT_MASK) begin
      r = {1'b1, 24'h000000, s.halt_mask};
    end else if (idx == hbw_pkg::IDX_DBG_MODE) begin
      r = {1'b1, 31'h00000000, s.in_debug};
    end else if (idx[9:3] == hbw_pkg::IDX_MAILBOX[9:3]) begin
      r = {1'b1, s.mailbox[idx[2:0]]};
    end else if (in_group(idx, hbw_pkg::IDX_IB_TARGET)) begin
      r = {1'b1, s.ib_target[k]};
    end else if (in_group(idx, hbw_pkg::IDX_IB_CTRL)) begin
      r = {1'b1, s.ib_ctrl[k]};
    end else if (in_group(idx, hbw_pkg::IDX_DW_FIRST)) begin
      r = {1'b1, s.dw_first[k]};
    end else if (in_group(idx, hbw_pkg::IDX_DW_SECOND)) begin
      r = {1'b1, s.dw_second[k]};
    end else if (in_group(idx, hbw_pkg::IDX_DW_CTRL)) begin
      r = {1'b1, s.dw_ctrl[k]};
    end else if (in_group(idx, hbw_pkg::IDX_RW_MASK)) begin
      r = {1'b1, s.rw_mask[k]};
    end else if (in_group(idx, hbw_pkg::IDX_RW_VALUE)) begin
      r = {1'b1, s.rw_value[k]};
    end else if (in_group(idx, hbw_pkg::IDX_RW_CTRL)) begin
      r = {1'b1, s.rw_ctrl[k]};
    end
    return r;
  endfunction

  hbw_pkg::hbw_state_t cur_r;
  hbw_pkg::hbw_state_t state_nxt;

  logic [9:0] idx;
  logic [1:0] k;
  logic [32:0] rd;
  logic wr_acc;
  logic [3:0] ib_hits;
  logic [3:0] dw_hits;
  logic [3:0] rw_hits;
  logic [3:0][2:0] ib_thr;
  logic host_req;
  logic dbg_return;

  assign idx = paddr[11:2];
  assign k = idx[1:0];
  assign rd = reg_read(cur_r, idx);
  assign wr_acc = psel && penable && pwrite && rd[32];
  assign host_req = wr_acc && idx == hbw_pkg::IDX_DBG_MODE
                    && pwdata[hbw_pkg::DMC_HOST_REQ];
  assign dbg_return = wr_acc && idx == hbw_pkg::IDX_DBG_MODE
                      && pwdata[hbw_pkg::DMC_RETURN];

  // ****************************************************
  // APB answer: zero wait states
  // ****************************************************
  assign pready = psel && penable;
  assign pslverr = psel && penable && !rd[32];
  assign prdata = cur_r.prdata;

  // ****************************************************
  // Core-side outputs
  // ****************************************************
  assign cfg_mbox_rdata = cur_r.mailbox[cfg_mbox_idx];
  assign thread_halt = cur_r.in_debug ? 8'hFF : cur_r.halt_mask;
  assign in_debug_mode = cur_r.in_debug;
  assign debug_enter = cur_r.enter_pulse;

  // ****************************************************
  // Match logic per unit
  // ****************************************************
  always_comb begin
    logic a_hit;
    logic b_hit;
    logic eq;
    a_hit = 1'b0;
    b_hit = 1'b0;
    eq = 1'b0;
    ib_hits = 4'h0;
    dw_hits = 4'h0;
    rw_hits = 4'h0;
    ib_thr = '0;
    for (int b = 0; b < NUM_UNITS; b++) begin
      for (int t = NUM_THREADS - 1; t >= 0; t--) begin
        eq = thr_pc[t] == cur_r.ib_target[b];
        if (thr_pc_valid[t] && thr_ok(cur_r.ib_ctrl[b], 3'(t))
            && (eq ^ cur_r.ib_ctrl[b][hbw_pkg::CTL_SELECT])) begin
          ib_hits[b] = 1'b1;
          ib_thr[b] = 3'(t);
        end
      end
      a_hit = mem_addr == cur_r.dw_first[b];
      b_hit = mem_addr == cur_r.dw_second[b];
      dw_hits[b] = mem_valid && thr_ok(cur_r.dw_ctrl[b], mem_thread)
        && (!mem_is_load || cur_r.dw_ctrl[b][hbw_pkg::CTL_LOAD])
        && (cur_r.dw_ctrl[b][hbw_pkg::CTL_SELECT] ?
            (a_hit || b_hit) : (a_hit && b_hit));
      eq = (res_id & cur_r.rw_mask[b])
           == (cur_r.rw_value[b] & cur_r.rw_mask[b]);
      rw_hits[b] = res_valid && thr_ok(cur_r.rw_ctrl[b], res_thread)
        && (cur_r.rw_ctrl[b][hbw_pkg::CTL_SELECT] ? !eq : eq);
    end
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic [1:0] u;
    u = 2'h0;
    state_nxt = cur_r;
    state_nxt.enter_pulse = 1'b0;
    if (psel && !penable) begin
      state_nxt.prdata = rd[31:0];
    end
    if (wr_acc) begin
      if (idx == hbw_pkg::IDX_EVT_TYPE) begin
        state_nxt.cause = pwdata[2:0];
        state_nxt.cause_thread = pwdata[15:8];
        state_nxt.cause_unit = pwdata[17:16];
      end else if (idx == hbw_pkg::IDX_EVT_DATA) begin
        state_nxt.evt_data = pwdata;
      end else if (idx == hbw_pkg::IDX_HALT_MASK) begin
        state_nxt.halt_mask = pwdata[7:0];
      end else if (idx[9:3] == hbw_pkg::IDX_MAILBOX[9:3]) begin
        state_nxt.mailbox[idx[2:0]] = pwdata;
      end else if (in_group(idx, hbw_pkg::IDX_IB_TARGET)) begin
        state_nxt.ib_target[k] = pwdata;
      end else if (in_group(idx, hbw_pkg::IDX_IB_CTRL)) begin
        state_nxt.ib_ctrl[k] = pwdata & hbw_pkg::IB_CTRL_WMASK;
      end else if (in_group(idx, hbw_pkg::IDX_DW_FIRST)) begin
        state_nxt.dw_first[k] = pwdata;
      end else if (in_group(idx, hbw_pkg::IDX_DW_SECOND)) begin
        state_nxt.dw_second[k] = pwdata;
      end else if (in_group(idx, hbw_pkg::IDX_DW_CTRL)) begin
        state_nxt.dw_ctrl[k] = pwdata & hbw_pkg::DW_CTRL_WMASK;
      end else if (in_group(idx, hbw_pkg::IDX_RW_MASK)) begin
        state_nxt.rw_mask[k] = pwdata;
      end else if (in_group(idx, hbw_pkg::IDX_RW_VALUE)) begin
        state_nxt.rw_value[k] = pwdata;
      end else if (in_group(idx, hbw_pkg::IDX_RW_CTRL)) begin
        state_nxt.rw_ctrl[k] = pwdata & hbw_pkg::RW_CTRL_WMASK;
      end
    end
    // Config side loses to a same-cycle APB write of that word
    if (cfg_mbox_wr && !(wr_acc && idx[9:3] == hbw_pkg::IDX_MAILBOX[9:3]
                         && idx[2:0] == cfg_mbox_idx)) begin
      state_nxt.mailbox[cfg_mbox_idx] = cfg_mbox_wdata;
    end
    if (cur_r.in_debug) begin
      if (dbg_return) begin
        state_nxt.in_debug = 1'b0;
      end
    end else if (ib_hits != 4'h0) begin
      u = first_hit(ib_hits);
      state_nxt.in_debug = 1'b1;
      state_nxt.enter_pulse = 1'b1;
      state_nxt.cause = hbw_pkg::CAUSE_IBREAK;
      state_nxt.cause_unit = u;
      state_nxt.cause_thread = {5'h00, ib_thr[u]};
    end else if (dw_hits != 4'h0) begin
      state_nxt.in_debug = 1'b1;
      state_nxt.enter_pulse = 1'b1;
      state_nxt.cause = hbw_pkg::CAUSE_DWATCH;
      state_nxt.cause_unit = first_hit(dw_hits);
      state_nxt.cause_thread = {5'h00, mem_thread};
      state_nxt.evt_data = mem_addr;
    end else if (rw_hits != 4'h0) begin
      state_nxt.in_debug = 1'b1;
      state_nxt.enter_pulse = 1'b1;
      state_nxt.cause = hbw_pkg::CAUSE_RWATCH;
      state_nxt.cause_unit = first_hit(rw_hits);
      state_nxt.cause_thread = {5'h00, res_thread};
      state_nxt.evt_data = res_id;
    end else if (dcall_valid) begin
      state_nxt.in_debug = 1'b1;
      state_nxt.enter_pulse = 1'b1;
      state_nxt.cause = hbw_pkg::CAUSE_DCALL;
      state_nxt.cause_unit = 2'h0;
      state_nxt.cause_thread = {5'h00, dcall_thread};
    end else if (host_req) begin
      state_nxt.in_debug = 1'b1;
      state_nxt.enter_pulse = 1'b1;
      state_nxt.cause = hbw_pkg::CAUSE_HOST;
      state_nxt.cause_unit = 2'h0;
      state_nxt.cause_thread = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r.evt_data <= hbw_pkg::WORD_RESET;
      cur_r.halt_mask <= hbw_pkg::HALT_RESET;
      cur_r.mailbox <= '0;
      cur_r.ib_target <= '0;
      cur_r.ib_ctrl <= {4{hbw_pkg::CTRL_RESET}};
      cur_r.dw_first <= '0;
      cur_r.dw_second <= '0;
      cur_r.dw_ctrl <= {4{hbw_pkg::CTRL_RESET}};
      cur_r.rw_mask <= '0;
      cur_r.rw_value <= '0;
      cur_r.rw_ctrl <= {4{hbw_pkg::CTRL_RESET}};
      cur_r.cause <= hbw_pkg::CAUSE_NONE;
      cur_r.cause_thread <= 8'h00;
      cur_r.cause_unit <= 2'h0;
      cur_r.in_debug <= 1'b0;
      cur_r.enter_pulse <= 1'b0;
      cur_r.prdata <= hbw_pkg::WORD_RESET;
    end else begin
      cur_r <= state_nxt;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ib0_eq;
    !cur_r.in_debug && thr_pc_valid[0] && cur_r.ib_ctrl[0][0]
    && cur_r.ib_ctrl[0][16] && !cur_r.ib_ctrl[0][1]
    && thr_pc[0] == cur_r.ib_target[0];
  endsequence

  sequence s_enter(logic [2:0] c);
    cur_r.in_debug && cur_r.cause == c && debug_enter;
  endsequence

  property p_ib_entry;
    s_ib0_eq |=> s_enter(hbw_pkg::CAUSE_IBREAK) ##0 cur_r.cause_unit == 2'h0;
  endproperty
  a_ib_entry: assert property (p_ib_entry)
    else $error("breakpoint 0 match did not enter debug");

  property p_dw_data;
    !cur_r.in_debug && ib_hits == 4'h0 && dw_hits != 4'h0
    |=> s_enter(hbw_pkg::CAUSE_DWATCH) ##0 cur_r.evt_data == $past(mem_addr);
  endproperty
  a_dw_data: assert property (p_dw_data)
    else $error("data watch did not record access address");

  property p_rw_data;
    !cur_r.in_debug && ib_hits == 4'h0 && dw_hits == 4'h0
    && rw_hits != 4'h0
    |=> s_enter(hbw_pkg::CAUSE_RWATCH) ##0 cur_r.evt_data == $past(res_id);
  endproperty
  a_rw_data: assert property (p_rw_data)
    else $error("resource watch did not record resource id");

  property p_halt_outside;
    wr_acc && idx == hbw_pkg::IDX_HALT_MASK
    |=> in_debug_mode || thread_halt == $past(pwdata[7:0]);
  endproperty
  a_halt_outside: assert property (p_halt_outside)
    else $error("halt output differs from mask outside debug");

  property p_return;
    cur_r.in_debug && dbg_return
    |=> !in_debug_mode ##0 thread_halt == $past(cur_r.halt_mask);
  endproperty
  a_return: assert property (p_return)
    else $error("return from debug did not apply halt mask");

  property p_cause_valid;
    $rose(in_debug_mode) |-> cur_r.cause inside {[3'h1:3'h5]} && debug_enter;
  endproperty
  a_cause_valid: assert property (p_cause_valid)
    else $error("debug entry with invalid cause");

  property p_lowest_unit;
    !cur_r.in_debug && ib_hits == 4'h0 && dw_hits != 4'h0
    |=> (($past(dw_hits) >> cur_r.cause_unit) & 4'h1) == 4'h1
    && ($past(dw_hits) & ((4'h1 << cur_r.cause_unit) - 4'h1)) == 4'h0;
  endproperty
  a_lowest_unit: assert property (p_lowest_unit)
    else $error("lowest firing watchpoint not reported");

  property p_mbox_shared;
    wr_acc && idx[9:3] == hbw_pkg::IDX_MAILBOX[9:3]
    && idx[2:0] == cfg_mbox_idx
    ##1 $stable(cfg_mbox_idx) |-> cfg_mbox_rdata == $past(pwdata);
  endproperty
  a_mbox_shared: assert property (p_mbox_shared)
    else $error("mailbox write not visible on config side");

  property p_host;
    !cur_r.in_debug && host_req && ib_hits == 4'h0 && dw_hits == 4'h0
    && rw_hits == 4'h0 && !dcall_valid
    |=> s_enter(hbw_pkg::CAUSE_HOST) ##1 !debug_enter;
  endproperty
  a_host: assert property (p_host)
    else $error("host request did not enter debug once");

endmodule

// file: bench/hbw_core_model.sv
`timescale 1ns/1ns

// *****
// Logical cores seen by the debug unit
// *****
module hbw_core_model (
  input wire logic pclk,
  input wire logic [7:0] thread_halt,
  output logic [7:0] thr_pc_valid,
  output logic [7:0][31:0] thr_pc,
  output logic mem_valid,
  output logic mem_is_load,
  output logic [2:0] mem_thread,
  output logic [31:0] mem_addr,
  output logic res_valid,
  output logic [2:0] res_thread,
  output logic [31:0] res_id,
  output logic dcall_valid,
  output logic [2:0] dcall_thread,
  output logic cfg_mbox_wr,
  output logic [2:0] cfg_mbox_idx,
  output logic [31:0] cfg_mbox_wdata
);
  initial begin
    thr_pc_valid = '0;
    thr_pc = '0;
    {mem_valid, mem_is_load, mem_thread, mem_addr} = '0;
    {res_valid, res_thread, res_id} = '0;
    {dcall_valid, dcall_thread} = '0;
    {cfg_mbox_wr, cfg_mbox_idx, cfg_mbox_wdata} = '0;
  end

  // Halted threads issue no PC (other ops ignore the halt); idle lines show inverted data
  task automatic issue_pc(input logic [2:0] t, input logic [31:0] pc);
    @(posedge pclk);
    if (thread_halt[t] !== 1'b1) begin
      thr_pc[t] <= pc;
      thr_pc_valid[t] <= 1'b1;
    end
    @(posedge pclk);
    thr_pc_valid[t] <= 1'b0;
    thr_pc[t] <= ~pc;
  endtask

  task automatic mem_op(input logic ld, input logic [2:0] t,
                        input logic [31:0] a);
    @(posedge pclk);
    {mem_valid, mem_is_load, mem_thread, mem_addr} <= {1'b1, ld, t, a};
    @(posedge pclk);
    {mem_valid, mem_is_load, mem_thread, mem_addr} <= {1'b0, ~ld, ~t, ~a};
  endtask

  task automatic res_op(input logic [2:0] t, input logic [31:0] id);
    @(posedge pclk);
    {res_valid, res_thread, res_id} <= {1'b1, t, id};
    @(posedge pclk);
    {res_valid, res_thread, res_id} <= {1'b0, ~t, ~id};
  endtask

  task automatic dcall(input logic [2:0] t);
    @(posedge pclk);
    {dcall_valid, dcall_thread} <= {1'b1, t};
    @(posedge pclk);
    {dcall_valid, dcall_thread} <= {1'b0, ~t};
  endtask

  task automatic mbox_wr(input logic [2:0] i, input logic [31:0] v);
    @(posedge pclk);
    {cfg_mbox_wr, cfg_mbox_idx, cfg_mbox_wdata} <= {1'b1, i, v};
    @(posedge pclk);
    {cfg_mbox_wr, cfg_mbox_idx, cfg_mbox_wdata} <= {1'b0, ~i, ~v};
  endtask
endmodule

// file: bench/test_hbw_unit.sv
`timescale 1ns/1ns

`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); \
  end \
end

module test_hbw_unit;
  logic pclk, presetn, psel, penable, pwrite, probe, mprobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg_mbox_rdata, d;
  logic pready, pslverr, in_debug_mode, debug_enter;
  logic [7:0] thread_halt, thr_pc_valid;
  logic [7:0][31:0] thr_pc;
  logic mem_valid, mem_is_load, res_valid, dcall_valid, cfg_mbox_wr;
  logic [2:0] mem_thread, res_thread, dcall_thread, cfg_mbox_idx;
  logic [31:0] mem_addr, res_id, cfg_mbox_wdata;
  logic [32:0] exp_q[$];
  logic [32:0] ev;
  logic [31:0] mb[8];
  logic [9:0] wb[5];
  int fail_count = 0;
  int tests_run = 0;

  hbw_unit u_hbw_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .thr_pc_valid, .thr_pc,
    .mem_valid, .mem_is_load, .mem_thread, .mem_addr, .res_valid,
    .res_thread, .res_id, .dcall_valid, .dcall_thread, .cfg_mbox_wr,
    .cfg_mbox_idx, .cfg_mbox_wdata, .cfg_mbox_rdata, .thread_halt,
    .in_debug_mode, .debug_enter);

  hbw_core_model u_hbw_core_model (.pclk, .thread_halt, .thr_pc_valid,
    .thr_pc, .mem_valid, .mem_is_load, .mem_thread, .mem_addr, .res_valid,
    .res_thread, .res_id, .dcall_valid, .dcall_thread, .cfg_mbox_wr,
    .cfg_mbox_idx, .cfg_mbox_wdata);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [32:0] nxt();
    if (exp_q.size() == 0) return 'x;
    return exp_q.pop_front();
  endfunction

  // *****
  // Result monitor
  // *****
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (debug_enter === 1'b1) begin
        ev = nxt();
        `CHK({24'h0, in_debug_mode, thread_halt}, ev)
      end
      if (probe === 1'b1) begin
        ev = nxt();
        `CHK({24'h0, in_debug_mode, thread_halt}, ev)
      end
      if (mprobe === 1'b1) begin
        ev = nxt();
        `CHK({1'b0, cfg_mbox_rdata}, ev)
      end
      if ((psel & penable & pready & ~pwrite) === 1'b1) begin
        ev = nxt();
        `CHK({pslverr, prdata}, ev)
      end
    end
  end

  // *****
  // APB master
  // *****
  task automatic apb(input logic w, input logic [9:0] i,
                     input logic [31:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] v);
    apb(1'b1, i, v);
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] v);
    exp_q.push_back({1'b0, v});
    apb(1'b0, i, 32'h0);
  endtask

  task automatic mask_chk(input logic [9:0] i, input logic [31:0] m);
    wr(i, 32'hFFFFFFFF);
    rd(i, m);
    wr(i, 32'h0);
  endtask

  task automatic probe_halt(input logic [7:0] m);
    @(posedge pclk);
    exp_q.push_back({25'h0, m});
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  task automatic probe_mbox(input logic [31:0] v);
    @(posedge pclk);
    exp_q.push_back({1'b0, v});
    mprobe <= 1'b1;
    @(posedge pclk);
    mprobe <= 1'b0;
  endtask

  // Entry note, then the event, then settle reads cause and data
  task automatic enter();
    exp_q.push_back(33'h0000001FF);
  endtask

  task automatic settle(input logic [2:0] c, input logic [1:0] u,
                        input logic [7:0] t, input logic dv,
                        input logic [31:0] dat);
    rd(hbw_pkg::IDX_EVT_TYPE, {14'h0, u, t, 5'h0, c});
    if (dv) rd(hbw_pkg::IDX_EVT_DATA, dat);
    wr(hbw_pkg::IDX_DBG_MODE, 32'h2);
  endtask

  task automatic quiet();
    repeat (3) @(posedge pclk);
  endtask

  // *****
  // Main sequence
  // *****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, probe, mprobe} = '0;
    presetn = 1'b0;
    wb = '{hbw_pkg::IDX_IB_TARGET, hbw_pkg::IDX_DW_FIRST,
           hbw_pkg::IDX_DW_SECOND, hbw_pkg::IDX_RW_MASK,
           hbw_pkg::IDX_RW_VALUE};
    void'($urandom(32'hE09D));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(hbw_pkg::IDX_IB_CTRL + 10'(i), 32'h0);
      rd(hbw_pkg::IDX_DW_CTRL + 10'(i), 32'h0);
      rd(hbw_pkg::IDX_RW_CTRL + 10'(i), 32'h0);
      mask_chk(hbw_pkg::IDX_IB_CTRL + 10'(i), 32'h00FF0003);
      mask_chk(hbw_pkg::IDX_DW_CTRL + 10'(i), 32'h00FF0007);
      mask_chk(hbw_pkg::IDX_RW_CTRL + 10'(i), 32'h00FF0003);
      for (int j = 0; j < 5; j++) begin
        d = $urandom;
        wr(wb[j] + 10'(i), d);
        rd(wb[j] + 10'(i), d);
      end
    end
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      mb[i] = d;
      wr(hbw_pkg::IDX_MAILBOX + 10'(i), d);
      rd(hbw_pkg::IDX_MAILBOX + 10'(i), d);
    end
    u_hbw_core_model.mbox_wr(3'h3, 32'hA5A50F0F);
    rd(hbw_pkg::IDX_MAILBOX + 10'h3, 32'hA5A50F0F);
    probe_mbox(mb[4]);
    rd(hbw_pkg::IDX_HALT_MASK, 32'h0);
    mask_chk(hbw_pkg::IDX_HALT_MASK, 32'h000000FF);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 10'h3FF, 32'h0);
    // Two breakpoints on the same PC, thread 5 only
    wr(hbw_pkg::IDX_IB_TARGET + 10'h1, 32'h00001200);
    wr(hbw_pkg::IDX_IB_TARGET + 10'h2, 32'h00001200);
    wr(hbw_pkg::IDX_IB_CTRL + 10'h1, 32'h00200001);
    wr(hbw_pkg::IDX_IB_CTRL + 10'h2, 32'h00200001);
    u_hbw_core_model.issue_pc(3'h3, 32'h00001200);
    quiet();
    enter();
    u_hbw_core_model.issue_pc(3'h5, 32'h00001200);
    settle(3'h3, 2'h1, 8'h05, 1'b0, 32'h0);
    wr(hbw_pkg::IDX_IB_CTRL + 10'h1, 32'h0);
    wr(hbw_pkg::IDX_IB_CTRL + 10'h2, 32'h00200003);
    u_hbw_core_model.issue_pc(3'h5, 32'h00001200);
    quiet();
    enter();
    u_hbw_core_model.issue_pc(3'h5, 32'h00001204);
    settle(3'h3, 2'h2, 8'h05, 1'b0, 32'h0);
    wr(hbw_pkg::IDX_IB_CTRL + 10'h2, 32'h0);
    // Data watch unit 3
    wr(hbw_pkg::IDX_DW_FIRST + 10'h3, 32'h00008000);
    wr(hbw_pkg::IDX_DW_SECOND + 10'h3, 32'h00008040);
    wr(hbw_pkg::IDX_DW_CTRL + 10'h3, 32'h00FF0001);
    u_hbw_core_model.mem_op(1'b0, 3'h2, 32'h00008000);
    quiet();
    wr(hbw_pkg::IDX_DW_CTRL + 10'h3, 32'h00FF0003);
    u_hbw_core_model.mem_op(1'b1, 3'h2, 32'h00008040);
    quiet();
    enter();
    u_hbw_core_model.mem_op(1'b0, 3'h2, 32'h00008040);
    settle(3'h4, 2'h3, 8'h02, 1'b1, 32'h00008040);
    wr(hbw_pkg::IDX_DW_CTRL + 10'h3, 32'h00FF0007);
    enter();
    u_hbw_core_model.mem_op(1'b1, 3'h1, 32'h00008000);
    settle(3'h4, 2'h3, 8'h01, 1'b1, 32'h00008000);
    wr(hbw_pkg::IDX_DW_SECOND + 10'h3, 32'h00008000);
    wr(hbw_pkg::IDX_DW_CTRL + 10'h3, 32'h00FF0001);
    enter();
    u_hbw_core_model.mem_op(1'b0, 3'h6, 32'h00008000);
    settle(3'h4, 2'h3, 8'h06, 1'b1, 32'h00008000);
    wr(hbw_pkg::IDX_DW_CTRL + 10'h3, 32'h0);
    // Resource watch unit 0, thread 7 only
    wr(hbw_pkg::IDX_RW_MASK, 32'h0000FF00);
    wr(hbw_pkg::IDX_RW_VALUE, 32'h0000AB00);
    wr(hbw_pkg::IDX_RW_CTRL, 32'h00800001);
    u_hbw_core_model.res_op(3'h6, 32'h1234AB99);
    quiet();
    enter();
    u_hbw_core_model.res_op(3'h7, 32'h1234AB99);
    settle(3'h5, 2'h0, 8'h07, 1'b1, 32'h1234AB99);
    wr(hbw_pkg::IDX_RW_CTRL, 32'h00800003);
    u_hbw_core_model.res_op(3'h7, 32'h1234AB99);
    quiet();
    enter();
    u_hbw_core_model.res_op(3'h7, 32'h00000000);
    settle(3'h5, 2'h0, 8'h07, 1'b1, 32'h00000000);
    wr(hbw_pkg::IDX_RW_CTRL, 32'h0);
    enter();
    u_hbw_core_model.dcall(3'h4);
    settle(3'h2, 2'h0, 8'h04, 1'b0, 32'h0);
    // Host entry, then return with a halt mask
    wr(hbw_pkg::IDX_HALT_MASK, 32'h00000021);
    probe_halt(8'h21);
    enter();
    wr(hbw_pkg::IDX_DBG_MODE, 32'h1);
    settle(3'h1, 2'h0, 8'h00, 1'b0, 32'h0);
    probe_halt(8'h21);
    wr(hbw_pkg::IDX_HALT_MASK, 32'h0);
    probe_halt(8'h00);
    quiet();
    if (exp_q.size() != 0) fail_count++;
    final_report();
  end
endmodule
